// ===== hw/crs_params.svh
// Constants for the completer request stream framer: sideband layout,
// credit limits and register map.
// Assumes inclusion by bare name from the design files.
`ifndef CRS_PARAMS_SVH
`define CRS_PARAMS_SVH

// Sideband field positions
`define CRS_SB_LEAD_BE_LO   0
`define CRS_SB_TRAIL_BE_LO  8
`define CRS_SB_BYTE_EN_LO   16
`define CRS_SB_START_LO     80
`define CRS_SB_START_PTR_LO 82
`define CRS_SB_START1_PTR   84
`define CRS_SB_END_LO       86
`define CRS_SB_END0_PTR_LO  88
`define CRS_SB_END1_PTR_LO  92
`define CRS_SB_ABORT        96
`define CRS_SB_HINT_LO      97
`define CRS_SB_PARITY_LO    119

// Credit counter
`define CRS_CREDIT_MAX      7'h20
`define CRS_CREDIT_RESET    6'h00

// Register map (byte addresses) and reset values
`define CRS_REG_CONTROL     12'h000
`define CRS_REG_STATUS      12'h004
`define CRS_CONTROL_RESET   1'b0
`define CRS_CTRL_STRADDLE   0
`define CRS_STAT_INFLIGHT   8
`define CRS_STAT_NP_PAUSED  9

// Bus responses
`define CRS_RESP_OKAY       2'b00
`define CRS_RESP_DECERR     2'b11

`endif

// ===== hw/crs_pkg.sv
// Types shared by the completer request stream framer.
// Assumes nothing of its surroundings.
package crs_pkg;

   // Packet arbiter state: which source owns the stream
   typedef enum logic [1:0] {
      CRS_IDLE      = 2'b00,
      CRS_POSTED    = 2'b01,
      CRS_NONPOSTED = 2'b10
   } crs_state_t;

endpackage

// ===== hw/crs_completer_request_stream.sv
// What this block does
// (RULE1) Drive 512-bit payload and 183-bit sideband, sideband meaningful only while valid.
// (RULE2) Packet end marks each TLP's final beat unstraddled; held 0 when straddled.
// (RULE3) Unstraddled: 16-bit Dword keep, contiguous, all ones except partial final beat.
// (RULE4) Straddled: keep all ones; user finds boundaries from start/end flags.
// (RULE5) Once a packet starts, valid stays high until its final beat moves.
// (RULE6) A beat moves only when valid and ready are both high.
// (RULE7) While ready low and valid high, hold all outputs and valid.
// (RULE8) Credit grant each cycle: 00 none, 01 adds one, 10/11 add two.
// (RULE9) Each delivered Non-Posted request takes one credit; none sent at zero.
// (RULE10) Posted TLPs keep flowing while Non-Posted delivery waits for credit.
// (RULE11) User may grant credit per cycle, or hold grant at 11 always.
// (RULE12) Credit grants accepted in any cycle, unrelated to packet boundaries.
// (RULE13) Credit level shown on 6 bits, saturating at 32.
// (RULE14) Credit level output may lag grants by pipeline cycles.
// (RULE15) Sideband 7:0 leading byte enables, low nibble first TLP, valid at start.
// (RULE16) Atomics and payload Messages get all-ones leading and trailing enables.
// (RULE17) Upper nibbles of both byte-enable fields held zero unless straddled.
// (RULE18) Sideband 15:8 trailing byte enables, qualified by valid and end flag.
// (RULE19) Sideband 79:16 per-byte payload valid mask, never set for descriptor bytes.
// (RULE20) Payload byte mask contiguous above two Dwords; may gap at two or fewer.
// (RULE21) Zero-length write moves its one-Dword payload with byte mask all zero.
// (RULE22) Sideband 81:80 start flags: 00 none, 01 one, 11 two, 10 forbidden.
// (RULE23) Sideband 87:86 end flags: 00 none, 01 one, 11 two, 10 forbidden.
// (RULE24) Buffer read error raises abort in last payload beat; user drops TLP.
// (RULE25) Sideband 182:119 holds odd parity of each payload byte.
// (RULE26) Credit counter clears to zero on reset.
//
// Assumes two internal sources (0 posted, 1 non-posted) that hold whole
// packets and keep their valid high from a packet's first beat to its last.
`timescale 1ns/100ps
`default_nettype none
`include "crs_params.svh"

module crs_completer_request_stream #(
   parameter int DATA_W = 512,
   parameter int SB_W   = 183
) (
   input  wire logic                  clk_sys,
   input  wire logic                  srst,
   input  wire logic                  clk_en,
   // Internal request sources, index 0 posted, index 1 non-posted
   input  wire logic [1:0]            src_valid,
   output logic      [1:0]            src_ready,
   input  wire logic [1:0][511:0]     src_payload,
   input  wire logic [1:0][15:0]      src_keep,
   input  wire logic [1:0]            src_last,
   input  wire logic [1:0][3:0]       src_lead_be,
   input  wire logic [1:0][3:0]       src_trail_be,
   input  wire logic [1:0][63:0]      src_byte_en,
   input  wire logic [1:0]            src_force_be,
   input  wire logic [1:0]            src_zero_len,
   input  wire logic [1:0]            src_read_error,
   // Completer request stream to user logic
   output logic      [511:0]          request_stream_payload,
   output logic      [182:0]          request_stream_sideband,
   output logic                       request_packet_end,
   output logic      [15:0]           request_dword_keep_mask,
   output logic                       request_stream_valid,
   input  wire logic                  request_stream_ready,
   input  wire logic [1:0]            nonposted_credit_grant,
   output logic      [5:0]            nonposted_credit_level,
   // AXI4-Lite register slave
   input  wire logic [11:0]           s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic      [1:0]            s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [11:0]           s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic      [31:0]           s_axi_rdata,
   output logic      [1:0]            s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready
);

   // Elaboration-time refusal of widths the fixed sideband layout cannot serve
   if (DATA_W != 512 || SB_W != 183) begin : g_bad_width
      $error("Only the 512-bit payload with 183-bit sideband is supported");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helper functions

   function automatic logic [63:0] odd_parity(input logic [511:0] data);
      logic [63:0] par;
      par = '0;
      for (int i = 0; i < 64; i++) begin
         par[i] = ~^data[i*8 +: 8];
      end
      return par;
   endfunction

   function automatic logic [1:0] grant_amount(input logic [1:0] code);
      logic [1:0] amt;
      case (code)
         2'b00:   amt = 2'h0;
         2'b01:   amt = 2'h1;
         default: amt = 2'h2;
      endcase
      return amt;
   endfunction

   function automatic logic [3:0] last_dword(input logic [15:0] keep);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (keep[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register file

   logic        straddle_cfg;
   logic        straddle_act;
   logic [6:0]  credit;
   logic [31:0] status_word;

   wire wr_take   = clk_en && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   wire rd_take   = clk_en && s_axi_arvalid && !s_axi_rvalid;
   wire wr_ctrl   = (s_axi_awaddr == `CRS_REG_CONTROL);
   wire wr_stat   = (s_axi_awaddr == `CRS_REG_STATUS);
   wire rd_ctrl   = (s_axi_araddr == `CRS_REG_CONTROL);
   wire rd_stat   = (s_axi_araddr == `CRS_REG_STATUS);

   assign s_axi_awready = wr_take;
   assign s_axi_wready  = wr_take;
   assign s_axi_arready = rd_take;

   crs_pkg::crs_state_t state;
   crs_pkg::crs_state_t next_state;

   wire np_paused = src_valid[1] && (credit == 7'h00);

   assign status_word = {22'h0, np_paused, (state != crs_pkg::CRS_IDLE),
                         2'h0, credit[5:0]};

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         straddle_cfg <= `CRS_CONTROL_RESET;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `CRS_RESP_OKAY;
      end else if (clk_en) begin
         if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_ctrl || wr_stat) ? `CRS_RESP_OKAY : `CRS_RESP_DECERR;
            if (wr_ctrl && s_axi_wstrb[0]) begin
               straddle_cfg <= s_axi_wdata[`CRS_CTRL_STRADDLE];
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= `CRS_RESP_OKAY;
      end else if (clk_en) begin
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= (rd_ctrl || rd_stat) ? `CRS_RESP_OKAY : `CRS_RESP_DECERR;
            s_axi_rdata  <= rd_ctrl ? {31'h0, straddle_cfg} :
                            rd_stat ? status_word : 32'h0;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Packet arbiter

   // Output slice can take a new beat when empty or when its beat moves
   wire slot_free = !request_stream_valid || request_stream_ready;  // [RULE6] [RULE7]

   // Posted wins when idle, so a starved non-posted source never blocks it
   wire pick_posted = src_valid[0];                                 // [RULE10]
   wire pick_np     = !src_valid[0] && src_valid[1] && (credit != 7'h00);  // [RULE9]

   logic       sel;
   logic       take;

   always_comb begin
      next_state = state;
      sel        = 1'b0;
      take       = 1'b0;
      case (state)
         crs_pkg::CRS_IDLE: begin
            if (pick_posted) begin
               sel  = 1'b0;
               take = slot_free;
            end else if (pick_np) begin
               sel  = 1'b1;
               take = slot_free;
            end
            if (take && !src_last[sel]) begin
               next_state = sel ? crs_pkg::CRS_NONPOSTED : crs_pkg::CRS_POSTED;
            end
         end
         crs_pkg::CRS_POSTED: begin
            sel  = 1'b0;
            take = slot_free && src_valid[0];
            if (take && src_last[0]) begin
               next_state = crs_pkg::CRS_IDLE;
            end
         end
         crs_pkg::CRS_NONPOSTED: begin
            sel  = 1'b1;
            take = slot_free && src_valid[1];
            if (take && src_last[1]) begin
               next_state = crs_pkg::CRS_IDLE;
            end
         end
         default: begin
            next_state = crs_pkg::CRS_IDLE;
         end
      endcase
   end

   assign src_ready = {clk_en && take && sel, clk_en && take && !sel};

   wire first_beat = (state == crs_pkg::CRS_IDLE);
   wire np_start   = take && sel && first_beat;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state        <= crs_pkg::CRS_IDLE;
         straddle_act <= `CRS_CONTROL_RESET;
      end else if (clk_en) begin
         state <= next_state;
         // Framing mode changes only between packets
         if (first_beat && !take && !request_stream_valid) begin
            straddle_act <= straddle_cfg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Non-posted credit

   logic [7:0] credit_sum;
   logic [6:0] next_credit;

   assign credit_sum = {1'b0, credit} + {6'h0, grant_amount(nonposted_credit_grant)}
                       - {7'h0, np_start};                          // [RULE8] [RULE9] [RULE12]
   assign next_credit = (credit_sum > {1'b0, `CRS_CREDIT_MAX}) ? `CRS_CREDIT_MAX
                        : credit_sum[6:0];                          // [RULE13]

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         credit                 <= {1'b0, `CRS_CREDIT_RESET};       // [RULE26]
         nonposted_credit_level <= `CRS_CREDIT_RESET;
      end else if (clk_en) begin
         credit                 <= next_credit;
         // Registered copy, so the visible level trails the counter
         nonposted_credit_level <= credit[5:0];                     // [RULE13] [RULE14]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Beat formatting

   logic [3:0]   hdr_trail_be;
   logic [3:0]   lead_be;
   logic [3:0]   trail_be;
   logic [63:0]  byte_en;
   logic [15:0]  keep;
   logic [182:0] sideband;
   logic         beat_last;

   assign beat_last = src_last[sel];
   assign lead_be   = src_force_be[sel] ? 4'hf : src_lead_be[sel];     // [RULE16]
   // Trailing enables come from the header, captured at the first beat
   assign trail_be  = first_beat ? (src_force_be[sel] ? 4'hf : src_trail_be[sel])
                                 : hdr_trail_be;                       // [RULE16] [RULE18]
   assign byte_en   = src_zero_len[sel] ? 64'h0 : src_byte_en[sel];  // [RULE19] [RULE20] [RULE21]
   assign keep      = straddle_act ? 16'hffff : src_keep[sel];       // [RULE3] [RULE4]

   always_comb begin
      sideband = '0;
      // Upper nibbles stay zero: one TLP per beat in either mode
      sideband[`CRS_SB_LEAD_BE_LO +: 4]  = first_beat ? lead_be : 4'h0;  // [RULE15] [RULE17]
      sideband[`CRS_SB_TRAIL_BE_LO +: 4] = trail_be;                    // [RULE18] [RULE17]
      sideband[`CRS_SB_BYTE_EN_LO +: 64] = byte_en;                     // [RULE19]
      sideband[`CRS_SB_START_LO +: 2]    = {1'b0, first_beat};          // [RULE22]
      sideband[`CRS_SB_END_LO +: 2]      = {1'b0, beat_last};           // [RULE23]
      sideband[`CRS_SB_END0_PTR_LO +: 4] = (straddle_act && beat_last)
                                           ? last_dword(src_keep[sel]) : 4'h0;
      sideband[`CRS_SB_ABORT]            = beat_last && src_read_error[sel];  // [RULE24]
      sideband[`CRS_SB_PARITY_LO +: 64]  = odd_parity(src_payload[sel]);      // [RULE25]
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output slice

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         request_stream_valid    <= 1'b0;
         request_stream_payload  <= '0;
         request_stream_sideband <= '0;
         request_packet_end      <= 1'b0;
         request_dword_keep_mask <= 16'h0;
         hdr_trail_be            <= 4'h0;
      end else if (clk_en) begin
         if (take) begin
            // Sources hold valid through a packet, so beats follow without gaps
            request_stream_valid    <= 1'b1;                              // [RULE5]
            request_stream_payload  <= src_payload[sel];                  // [RULE1]
            request_stream_sideband <= sideband;                          // [RULE1]
            request_packet_end      <= beat_last && !straddle_act;        // [RULE2]
            request_dword_keep_mask <= keep;
            if (first_beat) begin
               hdr_trail_be <= trail_be;
            end
         end else if (request_stream_ready) begin
            request_stream_valid <= 1'b0;                                 // [RULE6]
            // End flag never lingers on an empty slice
            request_packet_end   <= 1'b0;                                 // [RULE2]
         end
      end
   end

endmodule // crs_completer_request_stream

`default_nettype wire

// ===== verif/crs_stream_chk.sv
// Checker on the framer stream and credit ports.
// Bound into the framer top; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module crs_stream_chk (
   input wire logic         clk_sys,
   input wire logic         srst,
   input wire logic [1:0]   src_valid,
   input wire logic [1:0]   src_ready,
   input wire logic [511:0] request_stream_payload,
   input wire logic [182:0] request_stream_sideband,
   input wire logic         request_packet_end,
   input wire logic [15:0]  request_dword_keep_mask,
   input wire logic         request_stream_valid,
   input wire logic         request_stream_ready,
   input wire logic [1:0]   nonposted_credit_grant,
   input wire logic [5:0]   nonposted_credit_level
);
   wire         v  = request_stream_valid;
   wire         r  = request_stream_ready;
   wire [182:0] sb = request_stream_sideband;
   wire [15:0]  kp = request_dword_keep_mask;
   wire [5:0]   lv = nonposted_credit_level;
   logic [63:0] par;
   always_comb begin
      for (int i = 0; i < 64; i++) begin
         par[i] = ~^request_stream_payload[8*i +: 8];
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   a_stall_hold: assert property (v && !r |=> v && $stable(sb) && $stable(kp)
      && $stable(request_stream_payload) && $stable(request_packet_end)) else $error("stall moved");
   a_end_flag: assert property (request_packet_end |-> v && sb[86]) else $error("end bad");
   a_flag_codes: assert property (v |-> sb[81:80] != 2'b10 && sb[87:86] != 2'b10)
      else $error("flag code");
   a_odd_parity: assert property (v |-> sb[182:119] == par) else $error("parity");
   a_upper_nibble: assert property (v |-> sb[7:4] == 4'h0 && sb[15:12] == 4'h0)
      else $error("upper nibble");
   a_keep_contig: assert property (v |-> ((kp + 16'h0001) & kp) == 16'h0000)
      else $error("keep gap");
   a_no_gap: assert property (v && r && !sb[86] |=> v) else $error("valid gap");
   a_beat_answer: assert property ((src_valid & src_ready) != 2'b00 |=> v)
      else $error("beat lost");
   a_credit_max: assert property (lv <= 6'd32) else $error("credit over");
   a_credit_rise: assert property (lv > $past(lv) |-> lv <= $past(lv) + 6'd2
      && $past(nonposted_credit_grant, 2) != 2'b00) else $error("credit rise");
   a_credit_reset: assert property ($past(srst) |-> lv == 6'h00 && !v)
      else $error("reset state");
endmodule // crs_stream_chk
bind crs_completer_request_stream crs_stream_chk u_chk (.*);
`default_nettype wire

// ===== verif/crs_user_model.sv
// User logic consuming the request stream and granting credit.
// Ready pacing and grants follow the bench's commands.
`timescale 1ns/100ps
`default_nettype none
module crs_user_model (
   input  wire logic         clk_sys,
   input  wire logic         srst,
   input  wire logic         slow,
   input  wire logic [1:0]   grant_cmd,
   input  wire logic         request_stream_valid,
   input  wire logic [511:0] request_stream_payload,
   input  wire logic [182:0] request_stream_sideband,
   input  wire logic         request_packet_end,
   input  wire logic [15:0]  request_dword_keep_mask,
   output logic              request_stream_ready,
   output logic [1:0]        nonposted_credit_grant,
   output logic [7:0]        beats,
   output logic [15:0]       lead_seen,
   output logic [96:0]       last_sb,
   output logic [31:0]       last_word,
   output logic [15:0]       last_keep,
   output logic              last_end
);
   wire take = request_stream_valid && request_stream_ready;
   wire tend = take && request_stream_sideband[86];
   assign nonposted_credit_grant = grant_cmd;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         request_stream_ready <= 1'b0;
         beats <= 8'h00;
      end else begin
         request_stream_ready <= slow ? ~request_stream_ready : 1'b1;
         beats <= beats + 8'(take);
      end
      if (take && request_stream_sideband[80]) lead_seen <= request_stream_sideband[15:0];
      if (tend) last_sb <= request_stream_sideband[96:0];
      if (tend) last_word <= request_stream_payload[31:0];
      if (tend) last_keep <= request_dword_keep_mask;
      if (tend) last_end <= request_packet_end;
   end
endmodule // crs_user_model
`default_nettype wire

// ===== verif/crs_completer_request_stream_bench.sv
// Self-checking bench for the request stream framer.
// Drives both internal sources and the register bus.
`timescale 1ns/100ps
`default_nettype none
`include "crs_params.svh"
module crs_completer_request_stream_bench;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic clk_en = 1'b1;
   logic slow = 1'b0;
   logic [1:0] src_valid = '0, src_ready, src_last = '0, src_force_be = '0;
   logic [1:0] src_zero_len = '0, src_read_error = '0, nonposted_credit_grant, grant_cmd = '0;
   logic [1:0][511:0] src_payload = '0;
   logic [1:0][15:0] src_keep = '0;
   logic [1:0][3:0] src_lead_be = '0, src_trail_be = '0;
   logic [1:0][63:0] src_byte_en = '0;
   logic [511:0] request_stream_payload;
   logic [182:0] request_stream_sideband;
   logic [15:0] request_dword_keep_mask, lead_seen, last_keep;
   logic request_packet_end, request_stream_valid, request_stream_ready, last_end;
   logic [5:0] nonposted_credit_level;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, last_word, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [7:0] beats, b0;
   logic [96:0] last_sb;
   int miscompares = 0;
   int total_checks = 0;
   crs_completer_request_stream u_dut (.*);
   crs_user_model u_user (.*);
   initial forever #12.5 clk_sys = ~clk_sys;
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(string what, logic [127:0] exp, logic [127:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tmo(int n, int lim);
      if (n >= lim) begin
         miscompares++;
         finish_test();
      end
   endtask
   // Source holds valid and fields until src_ready is seen at an edge
   task automatic send(int s, int nb, logic [15:0] kl, logic fb, logic zl, logic re);
      int n;
      for (int b = 0; b < nb; b++) begin
         src_valid[s] <= 1'b1;
         src_last[s] <= (b == nb - 1);
         src_keep[s] <= (b == nb - 1) ? kl : 16'hffff;
         src_payload[s] <= {16{32'hc0de0000 + 32'(s * 256 + b)}};
         {src_lead_be[s], src_trail_be[s]} <= 8'h3c;
         src_byte_en[s] <= 64'h0000_0000_ffff_0000;
         {src_force_be[s], src_zero_len[s], src_read_error[s]} <= {fb, zl, re};
         n = 0;
         do @(posedge clk_sys); while (src_ready[s] !== 1'b1 && ++n < 100);
         tmo(n, 100);
      end
      src_valid[s] <= 1'b0;
   endtask
   task automatic wait_beats(int target);
      int n;
      for (n = 0; n < 100 && beats != target; n++) @(posedge clk_sys);
      tmo(n, 100);
   endtask
   task automatic axi_wr(logic [11:0] a, logic [31:0] d);
      int n;
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      n = 0;
      do @(posedge clk_sys); while (!(s_axi_awready && s_axi_wready) && ++n < 100);
      {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
      do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1 && ++n < 200);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      tmo(n, 200);
   endtask
   task automatic axi_rd(logic [11:0] a);
      int n;
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      n = 0;
      do @(posedge clk_sys); while (s_axi_arready !== 1'b1 && ++n < 100);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1 && ++n < 200);
      {rs, rd} = {s_axi_rresp, s_axi_rdata};
      s_axi_rready <= 1'b0;
      tmo(n, 200);
   endtask
   task automatic t_single();
      b0 = beats;
      send(0, 1, 16'h00ff, 1'b0, 1'b0, 1'b0);
      wait_beats(b0 + 1);
      chk("end", 1'b1, last_end);
      chk("keep", 16'h00ff, last_keep);
      chk("sb low", {64'h0000_0000_ffff_0000, 16'h0c03}, last_sb[79:0]);
      chk("sb flags", 17'h00041, last_sb[96:80]);
      chk("word", 32'hc0de0000, last_word);
      $display("test single done");
   endtask
   task automatic t_stall();
      slow <= 1'b1;
      b0 = beats;
      send(0, 3, 16'h0007, 1'b0, 1'b0, 1'b0);
      wait_beats(b0 + 3);
      chk("stall keep", 16'h0007, last_keep);
      chk("stall word", 32'hc0de0002, last_word);
      chk("stall lead", 20'h10c03, {3'b000, last_end, lead_seen});
      slow <= 1'b0;
      $display("test stall done");
   endtask
   task automatic t_np();
      b0 = beats;
      fork
         send(1, 1, 16'h000f, 1'b0, 1'b0, 1'b0);
         begin
            repeat (10) @(posedge clk_sys);
            chk("np held", b0, beats);
            send(0, 1, 16'h00ff, 1'b0, 1'b0, 1'b0);
            wait_beats(b0 + 1);
            chk("posted", 32'hc0de0000, last_word);
            grant_cmd <= 2'b01;
            @(posedge clk_sys);
            grant_cmd <= 2'b00;
         end
      join
      wait_beats(b0 + 2);
      chk("np sent", 32'hc0de0100, last_word);
      repeat (3) @(posedge clk_sys);
      chk("np credit", 6'h00, nonposted_credit_level);
      $display("test np done");
   endtask
   task automatic t_fields();
      b0 = beats;
      send(0, 1, 16'h00ff, 1'b1, 1'b0, 1'b0);
      wait_beats(b0 + 1);
      chk("forced", 16'h0f0f, lead_seen);
      send(0, 1, 16'h001f, 1'b0, 1'b1, 1'b0);
      wait_beats(b0 + 2);
      chk("zero len", 64'h0, last_sb[79:16]);
      send(0, 2, 16'h00ff, 1'b0, 1'b0, 1'b1);
      wait_beats(b0 + 4);
      chk("abort", 1'b1, last_sb[96]);
      $display("test fields done");
   endtask
   task automatic t_credit();
      logic [5:0] want [3] = '{6'd1, 6'd3, 6'd32};
      for (int i = 0; i < 3; i++) begin
         grant_cmd <= 2'(i + 1);
         repeat (i == 2 ? 20 : 1) @(posedge clk_sys);
         grant_cmd <= 2'b00;
         repeat (3) @(posedge clk_sys);
         chk("credit", want[i], nonposted_credit_level);
      end
      send(1, 1, 16'h000f, 1'b0, 1'b0, 1'b0);
      repeat (4) @(posedge clk_sys);
      chk("credit taken", 6'd31, nonposted_credit_level);
      $display("test credit done");
   endtask
   task automatic t_regs();
      axi_rd(`CRS_REG_CONTROL);
      chk("ctrl reset", {`CRS_RESP_OKAY, 32'h0}, {rs, rd});
      axi_wr(`CRS_REG_CONTROL, 32'h1);
      axi_rd(`CRS_REG_CONTROL);
      chk("ctrl", {`CRS_RESP_OKAY, 32'h1}, {rs, rd});
      axi_rd(`CRS_REG_STATUS);
      chk("status", 32'h1f, rd);
      axi_rd(12'h010);
      chk("bad rd", {`CRS_RESP_DECERR, 32'h0}, {rs, rd});
      axi_wr(12'h010, 32'h1);
      chk("bad wr", `CRS_RESP_DECERR, rs);
      b0 = beats;
      send(0, 1, 16'h000f, 1'b0, 1'b0, 1'b0);
      wait_beats(b0 + 1);
      chk("straddle", 18'h1ffff, {last_end, last_sb[86], last_keep});
      chk("end ptr", 4'h3, last_sb[91:88]);
      axi_wr(`CRS_REG_CONTROL, 32'h0);
      $display("test regs done");
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      chk("reset", 7'h00, {request_stream_valid, nonposted_credit_level});
      t_single();
      t_stall();
      t_np();
      t_fields();
      t_credit();
      t_regs();
      finish_test();
   end
endmodule // crs_completer_request_stream_bench
`default_nettype wire
